// ---- ext_bus_pkg.sv ----
// package of constants and carrier types for the external bus cycle sequencer
package ext_bus_pkg;
    // ------------------------------------------------------------------
    // geometry and reset values
    // ------------------------------------------------------------------
    localparam int          AREA_COUNT      = 8;
    localparam int          ADDR_WIDTH      = 24;
    localparam logic [1:0]  PROG_WAIT_RESET = 2'h3;
    localparam logic        STATE3_RESET    = 1'b1;
    localparam logic        WIDTH16_RESET   = 1'b1;
    localparam logic        PIN_WAIT_RESET  = 1'b0;
    localparam logic        IDLE_EN_RESET   = 1'b1;
    localparam logic [3:0]  BURST_SHORT     = 4'h4;
    localparam logic [3:0]  BURST_LONG      = 4'h8;
    localparam logic [2:0]  BURST_AREA      = 3'h0;

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_GAP   = 7'h02,
        ST_FIRST = 7'h04,
        ST_SECND = 7'h08,
        ST_WAIT  = 7'h10,
        ST_THIRD = 7'h20,
        ST_BURST = 7'h40
    } seq_t;

    // access request from the internal bus
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  word;
        logic                  fetch;
        logic [2:0]            area;
        logic [ADDR_WIDTH-1:0] addr;
        logic [15:0]           wdata;
    } req_t;

    // per-area and global configuration
    typedef struct packed {
        logic [AREA_COUNT-1:0]   state3;
        logic [AREA_COUNT-1:0]   width16;
        logic [2*AREA_COUNT-1:0] progWait;
        logic                    pinWaitEnable;
        logic                    burstRomSelect;
        logic                    burstCycleLength;
        logic                    burstWordLimit;
        logic                    idleBetweenAreaReads;
        logic                    idleWriteAfterRead;
        logic                    advancedMode;
    } cfg_t;

    // external pins
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [15:0]           dataOut;
        logic [1:0]            dataOe;
        logic [AREA_COUNT-1:0] areaChipSelectN;
        logic                  addressValidStrobeN;
        logic                  readStrobeN;
        logic                  highByteWriteStrobeN;
        logic                  lowByteWriteStrobeN;
    } pins_t;
endpackage

// ---- external_bus_cycle_timing.sv ----
// external bus cycle sequencer: basic, wait, burst rom and idle cycles
// Summary of operation
// - 8-bit space: upper lanes, low strobe high
// - 2-state areas never take wait states
// - 3-state areas may take wait states
// - 16-bit: even byte upper, odd lower
// - 0 to 3 program waits after second state
// - program waits first, then wait pin
// - wait pin low keeps adding wait states
// - one pin wait enable for all areas
// - power-on: 3-state, 3 waits, pin ignored
// - manual reset keeps settings and finishes cycle
// - area 0 may be burst rom space
// - burst only for cpu instruction fetches
// - burst limit four or eight words
// - initial burst cycle 3-state only; 2-state area0 never bursts
// - burst cycles one or two states, no waits
// - burst rom space forced to 16-bit
// - idle cycle is exactly one state
// - idle between reads of different areas, advanced
// - idle before write following a read
// - idle insertion enabled after reset
// - idle: next address, data floats, strobes high
// - high strobe upper lanes, low strobe lower
// - area chip select low during access
`timescale 1ns/1ps
module external_bus_cycle_timing #(
    parameter int AREAS = ext_bus_pkg::AREA_COUNT
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               manualResetN,
    input  wire ext_bus_pkg::req_t  req,
    input  wire ext_bus_pkg::cfg_t  cfgIn,
    input  wire logic               cfgWrite,
    input  wire logic               waitInN,
    input  wire logic [15:0]        dataIn,
    output logic                    reqReady,
    output logic                    cycleDone,
    output logic [15:0]             rdata,
    output ext_bus_pkg::cfg_t       cfg,
    output ext_bus_pkg::pins_t      pins
);
    // ------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------
    typedef struct packed {
        ext_bus_pkg::seq_t  seq;
        ext_bus_pkg::req_t  cur;
        ext_bus_pkg::cfg_t  cfg;
        ext_bus_pkg::pins_t pins;
        logic [1:0]         waitLeft;
        logic [3:0]         burstCnt;
        logic               lastRead;
        logic [2:0]         lastArea;
        logic               lastValid;
        logic               burstPhase;
        logic               done;
        logic [15:0]        rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------------
    // derived per-cycle attributes
    // ------------------------------------------------------------------
    logic       isBurstArea;
    logic       is16;
    logic       is3;
    logic [1:0] progW;
    logic       byteOdd;
    logic       idleNeeded;
    logic       canBurst;
    logic [3:0] burstMax;
    logic       reqIs16;

    // burst rom space forces 16-bit width and uses area0 state count
    always_comb begin
        isBurstArea = s_q.cfg.burstRomSelect && (s_q.cur.area == ext_bus_pkg::BURST_AREA);
        is16        = isBurstArea | s_q.cfg.width16[s_q.cur.area];
        is3         = s_q.cfg.state3[s_q.cur.area];
        // width of the waiting request, so its first state already uses the right lanes
        reqIs16     = (s_q.cfg.burstRomSelect && (req.area == ext_bus_pkg::BURST_AREA))
                      | s_q.cfg.width16[req.area];
        progW       = s_q.cfg.progWait[2*s_q.cur.area +: 2];
        byteOdd     = s_q.cur.addr[0];
        burstMax    = s_q.cfg.burstWordLimit ? ext_bus_pkg::BURST_LONG
                                             : ext_bus_pkg::BURST_SHORT;
        // next sequential fetch in the same area continues the burst
        canBurst    = isBurstArea && req.valid && req.fetch && s_q.cur.fetch
                      && !req.write && (req.area == ext_bus_pkg::BURST_AREA)
                      && (req.addr == s_q.cur.addr + ext_bus_pkg::ADDR_WIDTH'(2))
                      && (s_q.burstCnt < burstMax);
        idleNeeded  = s_q.lastValid && s_q.lastRead
                      && ((req.write && s_q.cfg.idleWriteAfterRead)
                          || (!req.write && s_q.cfg.idleBetweenAreaReads
                              && s_q.cfg.advancedMode
                              && (req.area != s_q.lastArea)));
    end

    // ready only when the sequencer can start a new cycle on the next edge
    assign reqReady  = (s_q.seq == ext_bus_pkg::ST_IDLE) && manualResetN;
    assign cycleDone = s_q.done;
    assign rdata     = s_q.rdata;
    assign cfg       = s_q.cfg;
    assign pins      = s_q.pins;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    function automatic ext_bus_pkg::pins_t drivePins(ext_bus_pkg::req_t r, logic w16,
                                                     logic strobe);
        ext_bus_pkg::pins_t p;
        p = '{addr: r.addr, dataOut: 16'h0000, dataOe: 2'h0,
              areaChipSelectN: '1, addressValidStrobeN: 1'b1, readStrobeN: 1'b1,
              highByteWriteStrobeN: 1'b1, lowByteWriteStrobeN: 1'b1};
        p.areaChipSelectN[r.area] = 1'b0;
        p.addressValidStrobeN = 1'b0;
        if (!r.write) begin
            p.readStrobeN = ~strobe;
        end else if (!w16) begin
            p.dataOut = {r.wdata[7:0], 8'h00};
            p.dataOe  = 2'h2;
            p.highByteWriteStrobeN = ~strobe;
        end else if (r.word) begin
            p.dataOut = r.wdata;
            p.dataOe  = 2'h3;
            p.highByteWriteStrobeN = ~strobe;
            p.lowByteWriteStrobeN  = ~strobe;
        end else if (r.addr[0]) begin
            p.dataOut = {8'h00, r.wdata[7:0]};
            p.dataOe  = 2'h1;
            p.lowByteWriteStrobeN = ~strobe;
        end else begin
            p.dataOut = {r.wdata[7:0], 8'h00};
            p.dataOe  = 2'h2;
            p.highByteWriteStrobeN = ~strobe;
        end
        return p;
    endfunction

    // idle pin state: all strobes high, data floating
    function automatic ext_bus_pkg::pins_t restPins(logic [ext_bus_pkg::ADDR_WIDTH-1:0] a);
        ext_bus_pkg::pins_t p;
        p = '{addr: a, dataOut: 16'h0000, dataOe: 2'h0,
              areaChipSelectN: '1, addressValidStrobeN: 1'b1, readStrobeN: 1'b1,
              highByteWriteStrobeN: 1'b1, lowByteWriteStrobeN: 1'b1};
        return p;
    endfunction

    // capture read data onto byte lanes, 8-bit space uses the upper lane
    function automatic logic [15:0] capture(ext_bus_pkg::req_t r, logic w16,
                                            logic [15:0] d);
        if (!w16 || (!r.word && !r.addr[0])) begin
            return {8'h00, d[15:8]};
        end else if (!r.word) begin
            return {8'h00, d[7:0]};
        end
        return d;
    endfunction

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (cfgWrite) begin
            s_d.cfg = cfgIn;
        end
        case (s_q.seq)
            ext_bus_pkg::ST_IDLE: begin
                s_d.pins = restPins(s_q.pins.addr);
                if (req.valid && manualResetN) begin
                    s_d.cur      = req;
                    s_d.burstCnt = 4'h1;
                    if (idleNeeded) begin
                        s_d.seq  = ext_bus_pkg::ST_GAP;
                        s_d.pins = restPins(req.addr);
                    end else begin
                        s_d.seq  = ext_bus_pkg::ST_FIRST;
                        s_d.pins = drivePins(req, reqIs16, 1'b0);
                    end
                end
            end
            ext_bus_pkg::ST_GAP: begin
                // single idle state, then the real cycle begins
                s_d.seq  = ext_bus_pkg::ST_FIRST;
                s_d.pins = drivePins(s_q.cur, is16, 1'b0);
            end
            ext_bus_pkg::ST_FIRST: begin
                s_d.seq      = ext_bus_pkg::ST_SECND;
                s_d.pins     = drivePins(s_q.cur, is16, 1'b1);
                s_d.waitLeft = is3 ? progW : 2'h0;
            end
            ext_bus_pkg::ST_SECND, ext_bus_pkg::ST_WAIT: begin
                s_d.pins = drivePins(s_q.cur, is16, 1'b1);
                if (!is3) begin
                    s_d.seq = ext_bus_pkg::ST_IDLE;
                end else if (s_q.waitLeft != 2'h0) begin
                    s_d.seq      = ext_bus_pkg::ST_WAIT;
                    s_d.waitLeft = s_q.waitLeft - 2'h1;
                end else if (s_q.cfg.pinWaitEnable && !waitInN && manualResetN) begin
                    // pin checked only once program waits ran out; a manual reset
                    // ignores the pin so the running cycle still completes
                    s_d.seq = ext_bus_pkg::ST_WAIT;
                end else begin
                    s_d.seq = ext_bus_pkg::ST_THIRD;
                end
                if (!is3) begin
                    s_d.rdata = capture(s_q.cur, is16, dataIn);
                    s_d.done  = 1'b1;
                end
            end
            ext_bus_pkg::ST_THIRD, ext_bus_pkg::ST_BURST: begin
                s_d.rdata = capture(s_q.cur, is16, dataIn);
                s_d.done  = 1'b1;
                if (canBurst && manualResetN) begin
                    // address steps while chip select and read stay low
                    s_d.cur        = req;
                    s_d.burstCnt   = s_q.burstCnt + 4'h1;
                    s_d.seq        = ext_bus_pkg::ST_BURST;
                    s_d.burstPhase = s_q.cfg.burstCycleLength;
                    s_d.pins       = drivePins(req, 1'b1, 1'b1);
                    s_d.done       = 1'b0;
                end else begin
                    s_d.seq = ext_bus_pkg::ST_IDLE;
                end
                if (s_q.seq == ext_bus_pkg::ST_BURST && s_q.burstPhase) begin
                    s_d.seq        = ext_bus_pkg::ST_BURST;
                    s_d.burstPhase = 1'b0;
                    s_d.cur        = s_q.cur;
                    s_d.burstCnt   = s_q.burstCnt;
                    s_d.pins       = s_q.pins;
                    s_d.done       = 1'b0;
                    s_d.rdata      = s_q.rdata;
                end
            end
            default: begin
                s_d.seq = ext_bus_pkg::ST_IDLE;
            end
        endcase
        // remember the finished cycle for idle decisions
        if (s_d.done) begin
            s_d.lastValid = 1'b1;
            s_d.lastRead  = !s_q.cur.write;
            s_d.lastArea  = s_q.cur.area;
            s_d.pins      = (s_d.seq == ext_bus_pkg::ST_IDLE) ? restPins(s_q.cur.addr)
                                                               : s_d.pins;
        end
    end

    // ------------------------------------------------------------------
    // state register: manual reset is not a reset, so settings survive it
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_q.seq  <= ext_bus_pkg::ST_IDLE;
            s_q.cur  <= '0;
            s_q.cfg  <= '{state3: {AREAS{ext_bus_pkg::STATE3_RESET}},
                          width16: {AREAS{ext_bus_pkg::WIDTH16_RESET}},
                          progWait: {AREAS{ext_bus_pkg::PROG_WAIT_RESET}},
                          pinWaitEnable: ext_bus_pkg::PIN_WAIT_RESET,
                          burstRomSelect: 1'b0, burstCycleLength: 1'b0,
                          burstWordLimit: 1'b0,
                          idleBetweenAreaReads: ext_bus_pkg::IDLE_EN_RESET,
                          idleWriteAfterRead: ext_bus_pkg::IDLE_EN_RESET,
                          advancedMode: 1'b1};
            s_q.pins <= '{addr: '0, dataOut: 16'h0000, dataOe: 2'h0,
                          areaChipSelectN: '1, addressValidStrobeN: 1'b1,
                          readStrobeN: 1'b1, highByteWriteStrobeN: 1'b1,
                          lowByteWriteStrobeN: 1'b1};
            s_q.waitLeft   <= 2'h0;
            s_q.burstCnt   <= 4'h0;
            s_q.lastRead   <= 1'b0;
            s_q.lastArea   <= 3'h0;
            s_q.lastValid  <= 1'b0;
            s_q.burstPhase <= 1'b0;
            s_q.done       <= 1'b0;
            s_q.rdata      <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_narrow_low_strobe: assert property (s_q.pins.dataOe == 2'h2 || !is16 |->
        (!is16 |-> s_q.pins.lowByteWriteStrobeN)) else $error("low strobe in 8-bit");
    a_two_state_nowait: assert property ((s_q.seq == ext_bus_pkg::ST_SECND) && !is3
        |=> s_q.seq == ext_bus_pkg::ST_IDLE) else $error("wait in 2-state");
    a_prog_wait_count: assert property ((s_q.seq == ext_bus_pkg::ST_FIRST) && is3
        && progW == 2'h3 |=> ##1 s_q.seq == ext_bus_pkg::ST_WAIT ##1
        s_q.seq == ext_bus_pkg::ST_WAIT) else $error("program waits short");
    a_pin_wait_hold: assert property ((s_q.seq == ext_bus_pkg::ST_WAIT) && is3
        && s_q.waitLeft == 2'h0 && s_q.cfg.pinWaitEnable && !waitInN && manualResetN
        |=> s_q.seq == ext_bus_pkg::ST_WAIT) else $error("pin wait ignored");
    a_pin_disabled: assert property ((s_q.seq == ext_bus_pkg::ST_WAIT)
        && s_q.waitLeft == 2'h0 && !s_q.cfg.pinWaitEnable
        |=> s_q.seq == ext_bus_pkg::ST_THIRD) else $error("pin wait when off");
    a_odd_byte_lane: assert property (s_q.pins.dataOe == 2'h1 |->
        s_q.pins.highByteWriteStrobeN) else $error("odd byte on upper lane");
    a_idle_one_state: assert property (s_q.seq == ext_bus_pkg::ST_GAP |=>
        s_q.seq == ext_bus_pkg::ST_FIRST) else $error("idle not one state");
    a_idle_pins_high: assert property (s_q.seq == ext_bus_pkg::ST_FIRST &&
        $past(s_q.seq) == ext_bus_pkg::ST_GAP |-> $past(s_q.pins.areaChipSelectN) == '1
        && $past(s_q.pins.dataOe) == 2'h0) else $error("idle pins active");
    a_burst_fetch_only: assert property ($rose(s_q.seq == ext_bus_pkg::ST_BURST) |->
        s_q.cur.fetch && !s_q.cur.write) else $error("burst on non-fetch");
    a_burst_limit: assert property (s_q.burstCnt <= ext_bus_pkg::BURST_LONG)
        else $error("burst too long");

    c_wait_cycle: cover property (s_q.seq == ext_bus_pkg::ST_WAIT);
    c_idle_cycle: cover property (s_q.seq == ext_bus_pkg::ST_GAP);
    c_burst_cycle: cover property (s_q.seq == ext_bus_pkg::ST_BURST);
    c_word_write: cover property (s_q.pins.dataOe == 2'h3);
endmodule // external_bus_cycle_timing

// ---- ext_mem_model.sv ----
// behavioural external memory with a wait pin, facing the bus pins
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic               ref_clk,
    input  wire ext_bus_pkg::pins_t pins,
    input  wire logic [3:0]         waitHold,
    output logic [15:0]             dataIn,
    output logic                    waitInN
);
    logic [15:0] mem [0:255];
    logic [15:0] lastQ;
    logic [3:0]  cntQ;
    logic        act;
    logic [7:0]  idx;
    // any read or write strobe low marks the data phase of a cycle
    assign act = !pins.readStrobeN || !pins.highByteWriteStrobeN || !pins.lowByteWriteStrobeN;
    assign idx = pins.addr[8:1];
    // wait pin held low for the first waitHold data states, pulled up otherwise
    assign waitInN = !(act && cntQ < waitHold);
    // undriven bus toggles so a stale value can never pass for read data
    assign dataIn = !pins.readStrobeN ? mem[idx] : ~lastQ;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
        lastQ = 16'h0000;
        cntQ = 4'h0;
    end
    // each write strobe commits only its own lane
    always @(posedge ref_clk) begin
        lastQ <= dataIn;
        cntQ <= act ? cntQ + 4'h1 : 4'h0;
        if (!pins.highByteWriteStrobeN) mem[idx][15:8] <= pins.dataOut[15:8];
        if (!pins.lowByteWriteStrobeN) mem[idx][7:0] <= pins.dataOut[7:0];
    end
endmodule // ext_mem_model

// ---- tb_top.sv ----
// self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rstn, manualResetN, cfgWrite, waitInN, reqReady, cycleDone;
    logic [15:0] dataIn, rdata, laneData;
    logic [3:0]  waitHold;
    logic [7:0]  csAny;
    logic [1:0]  oeAny;
    logic        hiSeen, loSeen;
    int          errors, num_checks, lat;
    ext_bus_pkg::req_t  req;
    ext_bus_pkg::cfg_t  cfgIn, cfg;
    ext_bus_pkg::pins_t pins, snap;

    external_bus_cycle_timing uut (.ref_clk(ref_clk), .rstn(rstn), .manualResetN(manualResetN),
        .req(req), .cfgIn(cfgIn), .cfgWrite(cfgWrite), .waitInN(waitInN), .dataIn(dataIn),
        .reqReady(reqReady), .cycleDone(cycleDone), .rdata(rdata), .cfg(cfg), .pins(pins));
    ext_mem_model mem (.ref_clk(ref_clk), .pins(pins), .waitHold(waitHold), .dataIn(dataIn),
        .waitInN(waitInN));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // all areas alike except area 1, which is 8-bit wide
    function automatic ext_bus_pkg::cfg_t mk(input logic s3, input logic [1:0] w,
                                             input logic pin, input logic idl);
        mk = '0;
        mk.state3 = {8{s3}};
        mk.width16 = 8'hfd;
        mk.progWait = {8{w}};
        mk.pinWaitEnable = pin;
        mk.idleBetweenAreaReads = idl;
        mk.idleWriteAfterRead = idl;
        mk.advancedMode = 1'b1;
    endfunction

    task automatic set_cfg(input ext_bus_pkg::cfg_t c);
        @(posedge ref_clk);
        cfgIn <= c;
        cfgWrite <= 1'b1;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
    endtask

    // one transfer; lat counts states from the one after taking to the done pulse
    task automatic access(input logic wr, input logic wd, input logic fe, input logic [2:0] ar,
                          input logic [23:0] ad, input logic [15:0] wv);
        int n;
        n = 0;
        lat = 0;
        csAny = 8'h00;
        oeAny = 2'h0;
        hiSeen = 1'b0;
        loSeen = 1'b0;
        @(posedge ref_clk);
        req <= '{valid: 1'b1, write: wr, word: wd, fetch: fe, area: ar, addr: ad, wdata: wv};
        do begin
            @(posedge ref_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 50);
        req.valid <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            #1;
            lat++;
            if (lat == 1) snap = pins;
            csAny |= ~pins.areaChipSelectN;
            oeAny |= pins.dataOe;
            hiSeen |= !pins.highByteWriteStrobeN;
            loSeen |= !pins.lowByteWriteStrobeN;
            if (!pins.highByteWriteStrobeN || !pins.lowByteWriteStrobeN) laneData = pins.dataOut;
            if (cycleDone === 1'b1) break;
            @(posedge ref_clk);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("state3", cfg.state3, {8{ext_bus_pkg::STATE3_RESET}});
        check("progWait", cfg.progWait, {8{ext_bus_pkg::PROG_WAIT_RESET}});
        check("pinWait", cfg.pinWaitEnable, ext_bus_pkg::PIN_WAIT_RESET);
        check("idleBits", {cfg.idleBetweenAreaReads, cfg.idleWriteAfterRead}, 2'h3);
        waitHold <= 4'h5;
        access(1'b0, 1'b1, 1'b0, 3'h2, 24'h000040, 16'h0000);
        check("resetLat", lat, 64'd7);
        waitHold <= 4'h0;
    endtask

    // program waits alone, then with the pin holding two states
    task automatic t_wait();
        for (int w = 0; w < 4; w++) begin
            set_cfg(mk(1'b1, 2'(w), 1'b0, 1'b0));
            access(1'b0, 1'b1, 1'b0, 3'h3, 24'h000040, 16'h0000);
            check("progLat", lat, 64'(4 + w));
            set_cfg(mk(1'b1, 2'(w), 1'b1, 1'b0));
            waitHold <= 4'h2;
            access(1'b0, 1'b1, 1'b0, 3'(w + 4), 24'h000040, 16'h0000);
            check("pinLat", lat, 64'(w > 2 ? 4 + w : 6));
            waitHold <= 4'h0;
        end
        set_cfg(mk(1'b0, 2'h3, 1'b1, 1'b0));
        waitHold <= 4'h3;
        access(1'b0, 1'b1, 1'b0, 3'h5, 24'h000040, 16'h0000);
        check("twoLatRd", lat, 64'd3);
        access(1'b1, 1'b1, 1'b0, 3'h5, 24'h000060, 16'h1111);
        check("twoLatWr", lat, 64'd3);
        waitHold <= 4'h0;
    endtask

    // byte and word lanes in 8-bit and 16-bit space, written then read back
    task automatic t_lanes();
        logic [2:0]  ar [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
        logic [23:0] ad [4] = '{24'h000011, 24'h000020, 24'h000023, 24'h000030};
        logic        wd [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        logic [1:0]  oe [4] = '{2'h2, 2'h2, 2'h1, 2'h3};
        logic [15:0] wv;
        set_cfg(mk(1'b0, 2'h0, 1'b0, 1'b0));
        for (int i = 0; i < 4; i++) begin
            wv = 16'hc030 + 16'(i * 16'h0101);
            access(1'b1, wd[i], 1'b0, ar[i], ad[i], wv);
            check("dataOe", oeAny, oe[i]);
            check("hiStrobe", hiSeen, oe[i][1]);
            check("loStrobe", loSeen, oe[i][0]);
            check("chipSel", csAny, 8'h01 << ar[i]);
            if (wd[i]) check("wordLane", laneData, wv);
            else check("byteLane", oe[i][1] ? laneData[15:8] : laneData[7:0], wv[7:0]);
            access(1'b0, wd[i], 1'b0, ar[i], ad[i], 16'h0000);
            check("readBack", wd[i] ? rdata : {8'h00, rdata[7:0]}, wd[i] ? wv : {8'h00, wv[7:0]});
        end
    endtask

    // idle state between reads of two areas and before a write after a read
    task automatic t_idle();
        ext_bus_pkg::cfg_t c;
        set_cfg(mk(1'b0, 2'h0, 1'b0, 1'b1));
        access(1'b0, 1'b1, 1'b0, 3'h2, 24'h000040, 16'h0000);
        access(1'b0, 1'b1, 1'b0, 3'h3, 24'h000042, 16'h0000);
        check("idleAreaLat", lat, 64'd4);
        check("idleCs", snap.areaChipSelectN, 8'hff);
        check("idleStrobes", {snap.addressValidStrobeN, snap.readStrobeN,
              snap.highByteWriteStrobeN, snap.lowByteWriteStrobeN, snap.dataOe}, 6'h3c);
        check("idleAddr", snap.addr, 24'h000042);
        access(1'b0, 1'b1, 1'b0, 3'h3, 24'h000044, 16'h0000);
        check("sameAreaLat", lat, 64'd3);
        access(1'b1, 1'b1, 1'b0, 3'h3, 24'h000044, 16'h2222);
        check("warLat", lat, 64'd4);
        access(1'b1, 1'b1, 1'b0, 3'h3, 24'h000046, 16'h3333);
        check("wawLat", lat, 64'd3);
        set_cfg(mk(1'b0, 2'h0, 1'b0, 1'b0));
        access(1'b0, 1'b1, 1'b0, 3'h2, 24'h000040, 16'h0000);
        access(1'b1, 1'b1, 1'b0, 3'h3, 24'h000048, 16'h4444);
        check("warOffLat", lat, 64'd3);
        c = mk(1'b0, 2'h0, 1'b0, 1'b1);
        c.advancedMode = 1'b0;
        set_cfg(c);
        access(1'b0, 1'b1, 1'b0, 3'h2, 24'h000040, 16'h0000);
        access(1'b0, 1'b1, 1'b0, 3'h3, 24'h000042, 16'h0000);
        check("normalModeLat", lat, 64'd3);
    endtask

    // area 0 as burst rom space: forced 16-bit, initial cycle sized by its own state count
    task automatic t_burst();
        ext_bus_pkg::cfg_t c;
        c = mk(1'b1, 2'h0, 1'b0, 1'b0);
        c.width16[0] = 1'b0;
        c.burstRomSelect = 1'b1;
        c.progWait[1:0] = 2'h1;
        set_cfg(c);
        access(1'b1, 1'b1, 1'b0, 3'h2, 24'h000050, 16'h3c5a);
        access(1'b0, 1'b0, 1'b0, 3'h0, 24'h000051, 16'h0000);
        check("burstOddByte", rdata[7:0], 8'h5a);
        check("dataReadLat", lat, 64'd5);
        access(1'b0, 1'b1, 1'b1, 3'h0, 24'h000050, 16'h0000);
        check("fetchLat3", lat, 64'd5);
        check("fetchData", rdata, 16'h3c5a);
        c.state3[0] = 1'b0;
        set_cfg(c);
        access(1'b0, 1'b1, 1'b1, 3'h0, 24'h000050, 16'h0000);
        check("fetchLat2", lat, 64'd3);
    endtask

    // manual reset refuses new work and keeps every setting
    task automatic t_manual();
        ext_bus_pkg::cfg_t c;
        c = mk(1'b0, 2'h2, 1'b1, 1'b0);
        c.burstWordLimit = 1'b1;
        set_cfg(c);
        @(posedge ref_clk);
        manualResetN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("mrReady", reqReady, 1'b0);
        manualResetN <= 1'b1;
        @(posedge ref_clk);
        check("mrCfg", cfg, c);
        access(1'b0, 1'b1, 1'b0, 3'h2, 24'h000040, 16'h0000);
        check("mrLat", lat, 64'd3);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // the whole run needs well under two thousand cycles
    initial begin
        #1000000;
        errors++;
        finish_test();
    end

    initial begin
        rstn = 1'b0;
        manualResetN = 1'b1;
        req = '0;
        cfgIn = '0;
        cfgWrite = 1'b0;
        waitHold = 4'h0;
        errors = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_wait();
        t_lanes();
        t_idle();
        t_burst();
        t_manual();
        finish_test();
    end
endmodule // tb_top
